/* File: rtl/ras_pkg.sv */
package ras_pkg;

	localparam int          PC_W         = 11;
	localparam int          DEPTH        = 8;
	localparam int          PTR_W        = 3;
	localparam int          IRQ_EN_BIT   = 7;
	localparam int          HIGH_BITS    = 3;

	localparam logic [7:0]  ADDR_POINTER = 8'hDF;
	localparam logic [3:0]  ADDR_ENTRY_HI_NIB = 4'hF;

	localparam logic [2:0]  PTR_RESET    = 3'h7;
	localparam logic        IRQ_EN_RESET = 1'b0;
	localparam logic [10:0] ENTRY_RESET  = 11'h000;
	localparam logic [2:0]  PTR_TOP      = 3'h7;
	localparam logic [2:0]  PTR_STEP     = 3'h1;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_PUSH,
		OP_POP
	} stack_op_t;

	typedef struct packed {
		logic             push;
		logic             interruptReturn;
		logic             subroutineReturn;
		logic [PC_W-1:0]  pc;
	} seq_req_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sys_reg_req_t;

endpackage

/* File: rtl/stack_cell.sv */
`timescale 1ns/1ps
`default_nettype none

module stack_cell #(
	parameter int W = 11
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         clkEn,
	// Load port.
	input  wire logic         load,
	input  wire logic [W-1:0] data,
	// Stored value.
	output logic      [W-1:0] q
);

	logic [W-1:0] value_r;
	logic [W-1:0] value_nxt;

	always_comb begin
		value_nxt = value_r;
		if (load) begin
			value_nxt = data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			value_r <= '0;
		end else if (clkEn) begin
			value_r <= value_nxt;
		end
	end

	assign q = value_r;

endmodule

`default_nettype wire

/* File: rtl/return_address_stack.sv */
`timescale 1ns/1ps
`default_nettype none

//Contract
// - Eight entries hold saved program counters for nested calls and interrupts.
// - A three-bit pointer selects the entry for the next push or pop.
// - Entry is eleven bits: high byte bits 2..0 and a full low byte.
// - Push decrements the pointer, pop increments it; order is last in first out.
// - Calls and interrupt entry both push the program counter.
// - Saved value is the program counter of the current opcode address.
// - Push at pointer p fills entry seven minus p; first push fills entry 0.
// - Interrupt return and subroutine return both pop the top entry, whichever kind of push saved it.
// - Every pop returns the most recent saved value to the program counter.
// - Pointer and all entry bytes are readable and writable system registers in bank 0.
// - Pointer register bit 7 is the global interrupt enable, reset to 0.
module return_address_stack (
	// Clock, reset and enable.
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     clkEn,
	// Sequencer requests.
	input  wire ras_pkg::seq_req_t        seqReq,
	// Restored program counter.
	output logic     [ras_pkg::PC_W-1:0]  popPc,
	output logic                          popValid,
	// System register port.
	input  wire ras_pkg::sys_reg_req_t    regReq,
	output logic     [7:0]                regRdData,
	// Global interrupt enable.
	output logic                          globalIrqEnable
);
	import ras_pkg::*;

	logic [PTR_W-1:0] pointer_r;
	logic [PTR_W-1:0] pointer_nxt;
	logic             irqEn_r;
	logic             irqEn_nxt;
	logic [PC_W-1:0]  popPc_r;
	logic [PC_W-1:0]  popPc_nxt;
	logic             popValid_r;
	logic             popValid_nxt;
	logic [7:0]       rdData_r;
	logic [7:0]       rdData_nxt;

	stack_op_t        op;
	logic [PTR_W-1:0] pushIdx;
	logic [PTR_W-1:0] popIdx;
	logic             ptrWrite;
	logic             entryWrite;
	logic [PTR_W-1:0] regIdx;
	logic             regHigh;

	logic [PC_W-1:0]  entryQ    [DEPTH];
	logic [PC_W-1:0]  entryData [DEPTH];
	logic             entryLoad [DEPTH];

	// Push wins over a pop issued in the same cycle.
	always_comb begin
		if (seqReq.push) begin
			op = OP_PUSH;
		end else if (seqReq.interruptReturn || seqReq.subroutineReturn) begin
			op = OP_POP;
		end else begin
			op = OP_NONE;
		end
	end

	assign pushIdx    = PTR_TOP - pointer_r;
	assign popIdx     = PTR_TOP - (pointer_r + PTR_STEP);
	assign ptrWrite   = regReq.wr && (regReq.addr == ADDR_POINTER);
	assign entryWrite = regReq.wr && (regReq.addr[7:4] == ADDR_ENTRY_HI_NIB);
	assign regIdx     = regReq.addr[3:1];
	assign regHigh    = regReq.addr[0];

	// A push takes priority over a software write to the same entry.
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			entryLoad[i] = 1'b0;
			entryData[i] = entryQ[i];
			if (op == OP_PUSH && pushIdx == PTR_W'(i)) begin
				entryLoad[i] = 1'b1;
				entryData[i] = seqReq.pc;
			end else if (entryWrite && regIdx == PTR_W'(i)) begin
				entryLoad[i] = 1'b1;
				if (regHigh) begin
					entryData[i] = {regReq.wdata[HIGH_BITS-1:0], entryQ[i][7:0]};
				end else begin
					entryData[i] = {entryQ[i][PC_W-1:8], regReq.wdata};
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : gCell
			stack_cell #(.W(PC_W)) uCell (
				.clk   (clk),
				.rst   (rst),
				.clkEn (clkEn),
				.load  (entryLoad[g]),
				.data  (entryData[g]),
				.q     (entryQ[g])
			);
		end
	endgenerate

	always_comb begin
		pointer_nxt  = pointer_r;
		irqEn_nxt    = irqEn_r;
		popPc_nxt    = popPc_r;
		popValid_nxt = 1'b0;
		rdData_nxt   = rdData_r;
		if (ptrWrite) begin
			pointer_nxt = regReq.wdata[PTR_W-1:0];
			irqEn_nxt   = regReq.wdata[IRQ_EN_BIT];
		end
		case (op)
			OP_PUSH: begin
				pointer_nxt = pointer_r - PTR_STEP;
			end
			OP_POP: begin
				pointer_nxt  = pointer_r + PTR_STEP;
				popPc_nxt    = entryQ[popIdx];
				popValid_nxt = 1'b1;
			end
			OP_NONE: begin
			end
			default: begin
			end
		endcase
		// Reads show the pointer and entries as they stood before this edge.
		if (regReq.rd) begin
			if (regReq.addr == ADDR_POINTER) begin
				rdData_nxt = {irqEn_r, 4'h0, pointer_r};
			end else if (regReq.addr[7:4] == ADDR_ENTRY_HI_NIB) begin
				if (regHigh) begin
					rdData_nxt = {5'h00, entryQ[regIdx][PC_W-1:8]};
				end else begin
					rdData_nxt = entryQ[regIdx][7:0];
				end
			end else begin
				rdData_nxt = 8'h00;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pointer_r  <= PTR_RESET;
			irqEn_r    <= IRQ_EN_RESET;
			popPc_r    <= ENTRY_RESET;
			popValid_r <= 1'b0;
			rdData_r   <= 8'h00;
		end else if (clkEn) begin
			pointer_r  <= pointer_nxt;
			irqEn_r    <= irqEn_nxt;
			popPc_r    <= popPc_nxt;
			popValid_r <= popValid_nxt;
			rdData_r   <= rdData_nxt;
		end
	end

	assign popPc           = popPc_r;
	assign popValid        = popValid_r;
	assign regRdData       = rdData_r;
	assign globalIrqEnable = irqEn_r;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	push_dec_a: assert property (clkEn && seqReq.push |=> pointer_r == PTR_W'($past(pointer_r) - PTR_STEP))
		else $error("pointer did not decrement on push");
	pop_inc_a: assert property (clkEn && !seqReq.push
		&& (seqReq.interruptReturn || seqReq.subroutineReturn)
		|=> pointer_r == PTR_W'($past(pointer_r) + PTR_STEP))
		else $error("pointer did not increment on pop");
	push_store_a: assert property (clkEn && seqReq.push
		|=> entryQ[PTR_TOP - $past(pointer_r)] == $past(seqReq.pc))
		else $error("push stored wrong value or entry");
	pop_restore_a: assert property (clkEn && seqReq.push ##1 clkEn && !seqReq.push
		&& (seqReq.interruptReturn || seqReq.subroutineReturn) && !regReq.wr
		|=> popPc == $past(seqReq.pc, 2) && popValid)
		else $error("pop did not return last pushed value");
	pop_pulse_a: assert property (clkEn && popValid && !seqReq.interruptReturn
		&& !seqReq.subroutineReturn |=> !popValid)
		else $error("pop strobe held too long");
	gie_write_a: assert property (clkEn && ptrWrite |=> globalIrqEnable == $past(regReq.wdata[7]))
		else $error("interrupt enable not written");
	ptr_wrap_a: assert property (clkEn && seqReq.push && pointer_r == 3'h0 |=> pointer_r == 3'h7)
		else $error("pointer did not wrap");
	ptr_read_a: assert property (clkEn && regReq.rd && regReq.addr == ADDR_POINTER
		|=> regRdData == {$past(irqEn_r), 4'h0, $past(pointer_r)})
		else $error("pointer register read wrong");
	high_pad_a: assert property (clkEn && regReq.rd && regReq.addr[7:4] == 4'hF && regReq.addr[0]
		|=> regRdData[7:3] == 5'h00)
		else $error("high byte upper bits not zero");
	// A frozen cycle must leave the pointer, popPc, popValid and the global interrupt enable untouched.
	hold_freeze_a: assert property (!clkEn |=> $stable(pointer_r) && $stable(popPc)
		&& $stable(popValid) && $stable(globalIrqEnable))
		else $error("state changed while clock enable low");
	pop_entry_a: assert property (clkEn && !seqReq.push
		&& (seqReq.interruptReturn || seqReq.subroutineReturn)
		|=> popValid && popPc == $past(entryQ[popIdx]))
		else $error("pop returned wrong entry");
	irq_keep_a: assert property (clkEn && !ptrWrite |=> globalIrqEnable == $past(globalIrqEnable))
		else $error("interrupt enable changed without a write");
	entry_high_a: assert property (clkEn && entryWrite && !seqReq.push && regHigh
		|=> entryQ[$past(regIdx)][PC_W-1:8] == $past(regReq.wdata[HIGH_BITS-1:0]))
		else $error("entry high byte not written");

	push_full_c: cover property (clkEn && seqReq.push && pointer_r == 3'h0);
	pop_irq_c: cover property (clkEn && popValid && $past(seqReq.interruptReturn));
	sw_entry_c: cover property (clkEn && entryWrite ##1 clkEn && regReq.rd);
	push_pop_c: cover property (clkEn && seqReq.push ##1 clkEn && seqReq.subroutineReturn);

endmodule

`default_nettype wire

/* File: dv/seq_model.sv */
`timescale 1ns/1ps
`default_nettype none

module seq_model
	import ras_pkg::*;
(
	// Requests towards the stack.
	output var ras_pkg::seq_req_t req
);
	initial req = '0;

	task automatic push(input logic [PC_W-1:0] pc);
		seq_req_t r;
		r      = '0;
		r.push = 1'b1;
		r.pc   = pc;
		req    = r;
	endtask

	// Both return kinds share one pop request each.
	task automatic pop(input logic irqRet);
		seq_req_t r;
		r                  = '0;
		r.interruptReturn  = irqRet;
		r.subroutineReturn = !irqRet;
		req                = r;
	endtask

	task automatic idle();
		req = '0;
	endtask
endmodule

`default_nettype wire

/* File: dv/return_address_stack_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module return_address_stack_tb;
	import ras_pkg::*;
	logic            clk = 1'b0;
	logic            rst = 1'b1;
	logic            clkEn = 1'b1;
	seq_req_t        seqReq;
	sys_reg_req_t    regReq = '0;
	logic [PC_W-1:0] popPc;
	logic            popValid;
	logic [7:0]      regRdData;
	logic            irqEnable;
	int              miscompares = 0;
	int              checks = 0;
	int              cycles = 0;

	always #2.5 clk = ~clk;

	seq_model i_seq_model (.req(seqReq));

	return_address_stack i_return_address_stack (
		.clk(clk), .rst(rst), .clkEn(clkEn), .seqReq(seqReq), .popPc(popPc),
		.popValid(popValid), .regReq(regReq), .regRdData(regRdData), .globalIrqEnable(irqEnable));

	task automatic end_of_test();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic step();
		@(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		step();
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		step();
		check(16'(regRdData), 16'(exp));
	endtask

	function automatic logic [PC_W-1:0] pcOf(input int k);
		return 11'(k * 291 + 165);
	endfunction

	// Pushes count values starting at pcOf(first), back to back.
	task automatic pushes(input int first, input int count);
		for (int k = 0; k < count; k++) begin
			i_seq_model.push(pcOf(first + k));
			step();
		end
		i_seq_model.idle();
	endtask

	task automatic t_reset();
		rd(ADDR_POINTER, 8'h07);
		check(16'(irqEnable), 16'h0000);
		for (int n = 0; n < 16; n++)
			rd(8'hF0 + 8'(n), 8'h00);
		rd(8'h20, 8'h00);
	endtask

	task automatic t_regs();
		wr(ADDR_POINTER, 8'h85);
		rd(ADDR_POINTER, 8'h85);
		check(16'(irqEnable), 16'h0001);
		wr(ADDR_POINTER, 8'h7F);
		rd(ADDR_POINTER, 8'h07);
		wr(8'hF3, 8'hFF);
		rd(8'hF3, 8'h07);
		wr(8'hF3, 8'h00);
		clkEn = 1'b0;
		i_seq_model.push(11'h7FF);
		step();
		clkEn = 1'b1;
		i_seq_model.idle();
		rd(ADDR_POINTER, 8'h07);
	endtask

	task automatic t_lifo();
		logic [PC_W-1:0] v;
		pushes(0, 8);
		rd(ADDR_POINTER, 8'h07);
		for (int n = 0; n < 8; n++) begin
			v = pcOf(n);
			rd(8'hF0 + 8'(2 * n), v[7:0]);
			rd(8'hF1 + 8'(2 * n), {5'h00, v[10:8]});
		end
		regReq = '0;
		for (int k = 7; k >= 0; k--) begin
			i_seq_model.pop(k[0]);
			step();
			check(16'(popValid), 16'h0001);
			check(16'(popPc), 16'(pcOf(k)));
		end
		i_seq_model.idle();
		step();
		check(16'(popValid), 16'h0000);
	endtask

	task automatic t_wrap();
		logic [PC_W-1:0] v;
		v = pcOf(16);
		pushes(8, 9);
		rd(ADDR_POINTER, 8'h06);
		rd(8'hF0, v[7:0]);
		regReq = '0;
		i_seq_model.pop(1'b0);
		step();
		check(16'(popPc), 16'(v));
		i_seq_model.push(pcOf(20));
		step();
		i_seq_model.pop(1'b0);
		step();
		check(16'(popValid), 16'h0001);
		check(16'(popPc), 16'(pcOf(20)));
		i_seq_model.idle();
	endtask

	initial begin
		repeat (4) @(posedge clk);
		#1;
		rst = 1'b0;
		t_reset();
		t_regs();
		t_lifo();
		t_wrap();
		step();
		end_of_test();
	end
endmodule

`default_nettype wire
